// ===== rtl/ir_link_regs.svh
`ifndef IR_LINK_REGS_SVH
`define IR_LINK_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define MCLK_HZ 50000000
`define ACT_IDLE_S 10
`define ACT_IDLE_CYCLES (`ACT_IDLE_S * `MCLK_HZ)
`define DISC_TIMEOUT_MS 3000
`define DISC_TIMEOUT_CYCLES (`DISC_TIMEOUT_MS * (`MCLK_HZ / 1000))

// ----------------------------------------
// Advertised link parameters
// ----------------------------------------
// 9600 baud
`define LINK_BAUD 14'h2580
`define TURN_MS 8'h0A
`define WINDOW_FRAMES 4'h1
`define DISC_WAIT_S 8'h03
`define CLAIM_SLOT 8'h00

// ----------------------------------------
// Host buffering
// ----------------------------------------
`define HOST_FIFO_DEPTH 8
`define HOST_FIFO_WIDTH 8

`endif

// ===== rtl/ir_link_pkg.sv
package ir_link_pkg;

	// ----------------------------------------
	// Connection states
	// ----------------------------------------
	typedef enum logic [2:0] {
		LS_NDM_IDLE,
		LS_NDM_CLAIMED,
		LS_DISC_LINK,
		LS_DISC_IAS,
		LS_NCM
	} link_state_t;

	// ----------------------------------------
	// Decoded frames and responses
	// ----------------------------------------
	typedef enum logic [3:0] {
		RX_XID,
		RX_BCAST_ID,
		RX_SNRM,
		RX_IAS_OPEN,
		RX_IAS_QUERY,
		RX_DATA_OPEN,
		RX_INFO,
		RX_POLL,
		RX_CLOSE
	} rx_kind_t;

	typedef enum logic [3:0] {
		TX_NONE,
		TX_XID_RSP,
		TX_UA_PARAMS,
		TX_IAS_CONFIRM,
		TX_IAS_ANSWER,
		TX_DATA_CONFIRM,
		TX_INFO,
		TX_KEEPALIVE,
		TX_REJECT,
		TX_CLOSE_CONFIRM
	} tx_kind_t;

	typedef enum logic [1:0] {
		IAS_SERVICE_NAME,
		IAS_SERVICE_ADDR,
		IAS_CAPABILITIES,
		IAS_UNKNOWN
	} ias_item_t;

endpackage : ir_link_pkg

// ===== rtl/ir_idle_timer.sv
`timescale 1ns/1ns
`default_nettype none

module ir_idle_timer #(
	parameter int unsigned LIMIT = 1000
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Control
	input wire logic restart_i,
	input wire logic run_i,
	// Status
	output logic expired_o
);

	localparam logic [31:0] LAST = 32'(LIMIT - 1);

	typedef struct packed {
		logic [31:0] cnt;
		logic expired;
	} tmr_t;

	tmr_t state_ff;
	tmr_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		if (restart_i || !run_i) begin
			nxt_state.cnt = 32'h0;
			nxt_state.expired = 1'b0;
		end else if (!state_ff.expired) begin
			if (state_ff.cnt >= LAST) begin
				nxt_state.expired = 1'b1;
			end else begin
				nxt_state.cnt = state_ff.cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign expired_o = state_ff.expired;

endmodule : ir_idle_timer

`default_nettype wire

// ===== rtl/ir_host_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module ir_host_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8,
	localparam int unsigned CW = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// Status
	output logic [CW-1:0] level_o
);

	// ----------------------------------------
	// Shift register storage
	// ----------------------------------------
	// Head always sits in entry 0 so the output is a plain flop
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] data;
		logic [CW-1:0] level;
		logic valid;
		// Kept as its own flop so ready leaves the block straight from a register
		logic room;
	} fifo_t;

	fifo_t state_ff;
	fifo_t nxt_state;
	logic push;
	logic pop;
	logic [CW-1:0] widx;

	always_comb begin
		nxt_state = state_ff;
		push = in_valid_i && state_ff.room;
		pop = out_ready_i && state_ff.valid;
		widx = state_ff.level - CW'(pop);
		for (int i = 0; i < DEPTH; i++) begin
			if (pop && i < DEPTH - 1) begin
				nxt_state.data[i] = state_ff.data[i + 1];
			end
			if (push && widx == CW'(i)) begin
				nxt_state.data[i] = in_data_i;
			end
		end
		nxt_state.level = state_ff.level + CW'(push) - CW'(pop);
		nxt_state.valid = nxt_state.level != '0;
		nxt_state.room = nxt_state.level != CW'(DEPTH);
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_ff <= '{room: 1'b1, default: '0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign in_ready_o = state_ff.room;
	assign out_valid_o = state_ff.valid;
	assign out_data_o = state_ff.data[0];
	assign level_o = state_ff.level;

endmodule : ir_host_fifo

`default_nettype wire

// ===== rtl/ir_link_connection_manager.sv
`timescale 1ns/1ns
`default_nettype none
`include "ir_link_regs.svh"

module ir_link_connection_manager #(
	parameter int unsigned ACT_IDLE_CYCLES = `ACT_IDLE_CYCLES,
	parameter int unsigned DISC_TIMEOUT_CYCLES = `DISC_TIMEOUT_CYCLES,
	parameter int unsigned FIFO_DEPTH = `HOST_FIFO_DEPTH,
	localparam int unsigned LW = $clog2(FIFO_DEPTH + 1)
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Decoded frames from the infrared framer
	input wire logic rx_activity_i,
	input wire logic rx_frame_valid_i,
	input wire logic rx_crc_ok_i,
	input wire ir_link_pkg::rx_kind_t rx_kind_i,
	input wire logic [7:0] rx_slot_i,
	input wire logic [7:0] rx_addr_i,
	input wire ir_link_pkg::ias_item_t rx_ias_item_i,
	input wire logic rx_byte_valid_i,
	input wire logic [7:0] rx_byte_i,
	// Response requests to the infrared framer
	output logic tx_req_o,
	output ir_link_pkg::tx_kind_t tx_kind_o,
	output logic [7:0] tx_slot_o,
	output logic [7:0] tx_conn_addr_o,
	output ir_link_pkg::ias_item_t tx_ias_item_o,
	output logic tx_modem_o,
	output logic [13:0] tx_baud_o,
	output logic [7:0] tx_turn_ms_o,
	output logic [3:0] tx_window_o,
	output logic [7:0] tx_disc_wait_o,
	// Payload toward the infrared framer
	output logic tx_byte_valid_o,
	input wire logic tx_byte_ready_i,
	output logic [7:0] tx_byte_o,
	// Host UART side
	input wire logic host_rx_valid_i,
	input wire logic [7:0] host_rx_byte_i,
	output logic host_rx_ready_o,
	output logic host_tx_valid_o,
	output logic [7:0] host_tx_byte_o,
	output logic cts_b_o,
	output logic dsr_b_o,
	output logic dcd_b_o,
	output logic ri_b_o,
	// Status
	output logic ir_activity_indicator_o,
	output ir_link_pkg::link_state_t link_state_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		ir_link_pkg::link_state_t st;
		logic tx_req;
		ir_link_pkg::tx_kind_t tx_kind;
		logic [7:0] conn_addr;
		ir_link_pkg::ias_item_t ias_item;
		logic act;
		logic cts_b;
		logic dsr_b;
		logic host_tx_valid;
		logic [7:0] host_tx_byte;
	} mgr_t;

	mgr_t state_ff;
	mgr_t nxt_state;

	logic good_frame;
	logic disc_run;
	logic disc_expired;
	logic act_expired;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [LW-1:0] fifo_level;

	function automatic mgr_t answer(input mgr_t s, input ir_link_pkg::tx_kind_t k);
		mgr_t r;
		r = s;
		r.tx_req = 1'b1;
		r.tx_kind = k;
		return r;
	endfunction : answer

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	assign good_frame = rx_frame_valid_i && rx_crc_ok_i;
	// NDM may legally last forever, so only discovery and connect are timed
	assign disc_run = state_ff.st inside {ir_link_pkg::LS_DISC_LINK,
		ir_link_pkg::LS_DISC_IAS, ir_link_pkg::LS_NCM};

	ir_idle_timer #(
		.LIMIT(DISC_TIMEOUT_CYCLES)
	) u_disc_timer (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.restart_i(good_frame),
		.run_i(disc_run),
		.expired_o(disc_expired)
	);

	ir_idle_timer #(
		.LIMIT(ACT_IDLE_CYCLES)
	) u_act_timer (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.restart_i(rx_activity_i || rx_frame_valid_i),
		.run_i(state_ff.act),
		.expired_o(act_expired)
	);

	// ----------------------------------------
	// Host to link buffer
	// ----------------------------------------
	// Host bytes only enter while connected; outside NCM CTS blocks the host anyway
	assign fifo_in_valid = host_rx_valid_i && state_ff.st == ir_link_pkg::LS_NCM;

	ir_host_fifo #(
		.WIDTH(`HOST_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_host_fifo (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(host_rx_byte_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(tx_byte_ready_i),
		.out_data_o(tx_byte_o),
		.level_o(fifo_level)
	);

	// ----------------------------------------
	// Connection sequencer
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_state.tx_req = 1'b0;
		if (rx_frame_valid_i && !rx_crc_ok_i) begin
			if (state_ff.st == ir_link_pkg::LS_NCM) begin
				nxt_state = answer(state_ff, ir_link_pkg::TX_REJECT);
			end
		end else if (rx_frame_valid_i) begin
			unique case (state_ff.st)
				ir_link_pkg::LS_NDM_IDLE, ir_link_pkg::LS_NDM_CLAIMED: begin
					if (rx_kind_i == ir_link_pkg::RX_XID && rx_slot_i == `CLAIM_SLOT) begin
						nxt_state = answer(state_ff, ir_link_pkg::TX_XID_RSP);
						nxt_state.st = ir_link_pkg::LS_NDM_CLAIMED;
					end else if (rx_kind_i == ir_link_pkg::RX_BCAST_ID &&
						state_ff.st == ir_link_pkg::LS_NDM_CLAIMED) begin
						nxt_state.st = ir_link_pkg::LS_DISC_LINK;
					end
				end
				ir_link_pkg::LS_DISC_LINK: begin
					if (rx_kind_i == ir_link_pkg::RX_SNRM) begin
						nxt_state = answer(state_ff, ir_link_pkg::TX_UA_PARAMS);
						nxt_state.conn_addr = rx_addr_i;
						nxt_state.st = ir_link_pkg::LS_DISC_IAS;
					end else if (rx_kind_i == ir_link_pkg::RX_POLL) begin
						nxt_state = answer(state_ff, ir_link_pkg::TX_KEEPALIVE);
					end
				end
				ir_link_pkg::LS_DISC_IAS: begin
					unique case (rx_kind_i)
						ir_link_pkg::RX_IAS_OPEN: begin
							nxt_state = answer(state_ff, ir_link_pkg::TX_IAS_CONFIRM);
						end
						ir_link_pkg::RX_IAS_QUERY: begin
							nxt_state = answer(state_ff, ir_link_pkg::TX_IAS_ANSWER);
							nxt_state.ias_item = rx_ias_item_i;
						end
						ir_link_pkg::RX_DATA_OPEN: begin
							nxt_state = answer(state_ff, ir_link_pkg::TX_DATA_CONFIRM);
							nxt_state.st = ir_link_pkg::LS_NCM;
						end
						ir_link_pkg::RX_POLL: begin
							nxt_state = answer(state_ff, ir_link_pkg::TX_KEEPALIVE);
						end
						ir_link_pkg::RX_CLOSE: begin
							nxt_state = answer(state_ff, ir_link_pkg::TX_CLOSE_CONFIRM);
							nxt_state.st = ir_link_pkg::LS_NDM_IDLE;
						end
						default: begin
						end
					endcase
				end
				ir_link_pkg::LS_NCM: begin
					unique case (rx_kind_i)
						ir_link_pkg::RX_INFO, ir_link_pkg::RX_POLL: begin
							if (fifo_out_valid) begin
								nxt_state = answer(state_ff, ir_link_pkg::TX_INFO);
							end else begin
								nxt_state = answer(state_ff, ir_link_pkg::TX_KEEPALIVE);
							end
						end
						ir_link_pkg::RX_CLOSE: begin
							nxt_state = answer(state_ff, ir_link_pkg::TX_CLOSE_CONFIRM);
							nxt_state.st = ir_link_pkg::LS_NDM_IDLE;
						end
						default: begin
						end
					endcase
				end
			endcase
		end

		// A good-CRC frame in the same cycle restarts the timer, so it beats the timeout
		if (disc_expired && !good_frame) begin
			nxt_state.st = ir_link_pkg::LS_NDM_IDLE;
		end

		if (good_frame && rx_kind_i == ir_link_pkg::RX_XID) begin
			nxt_state.act = 1'b1;
		end else if (act_expired) begin
			nxt_state.act = 1'b0;
		end

		// CTS lags the buffer by one cycle; the buffer refuses overflow meanwhile
		nxt_state.cts_b = !(nxt_state.st == ir_link_pkg::LS_NCM &&
			LW'(FIFO_DEPTH) != fifo_level && fifo_in_ready);
		nxt_state.dsr_b = nxt_state.st != ir_link_pkg::LS_NCM;
		nxt_state.host_tx_valid = rx_byte_valid_i && state_ff.st == ir_link_pkg::LS_NCM;
		if (rx_byte_valid_i) begin
			nxt_state.host_tx_byte = rx_byte_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_ff <= '{
				st: ir_link_pkg::LS_NDM_IDLE,
				tx_kind: ir_link_pkg::TX_NONE,
				ias_item: ir_link_pkg::IAS_SERVICE_NAME,
				cts_b: 1'b1,
				dsr_b: 1'b1,
				default: '0
			};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Advertised parameters are fixed flops; the link can never leave 9600 baud
	logic [13:0] baud_ff;
	logic [7:0] turn_ff;
	logic [3:0] window_ff;
	logic [7:0] wait_ff;
	logic modem_ff;

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			baud_ff <= `LINK_BAUD;
			turn_ff <= `TURN_MS;
			window_ff <= `WINDOW_FRAMES;
			wait_ff <= `DISC_WAIT_S;
			modem_ff <= 1'b1;
		end else begin
			baud_ff <= `LINK_BAUD;
			turn_ff <= `TURN_MS;
			window_ff <= `WINDOW_FRAMES;
			wait_ff <= `DISC_WAIT_S;
			modem_ff <= 1'b1;
		end
	end

	logic [7:0] slot_ff;
	logic dcd_b_ff;
	logic ri_b_ff;

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			slot_ff <= `CLAIM_SLOT;
			dcd_b_ff <= 1'b1;
			ri_b_ff <= 1'b1;
		end else begin
			slot_ff <= `CLAIM_SLOT;
			dcd_b_ff <= 1'b1;
			ri_b_ff <= 1'b1;
		end
	end

	assign tx_req_o = state_ff.tx_req;
	assign tx_kind_o = state_ff.tx_kind;
	assign tx_slot_o = slot_ff;
	assign tx_conn_addr_o = state_ff.conn_addr;
	assign tx_ias_item_o = state_ff.ias_item;
	assign tx_modem_o = modem_ff;
	assign tx_baud_o = baud_ff;
	assign tx_turn_ms_o = turn_ff;
	assign tx_window_o = window_ff;
	assign tx_disc_wait_o = wait_ff;
	assign tx_byte_valid_o = fifo_out_valid;
	assign host_rx_ready_o = fifo_in_ready;
	assign host_tx_valid_o = state_ff.host_tx_valid;
	assign host_tx_byte_o = state_ff.host_tx_byte;
	assign cts_b_o = state_ff.cts_b;
	assign dsr_b_o = state_ff.dsr_b;
	assign dcd_b_o = dcd_b_ff;
	assign ri_b_o = ri_b_ff;
	assign ir_activity_indicator_o = state_ff.act;
	assign link_state_o = state_ff.st;

endmodule : ir_link_connection_manager

`default_nettype wire

// ===== tb/ir_link_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module ir_link_monitor (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Frame inputs
	input wire logic rx_frame_valid_i,
	input wire logic rx_crc_ok_i,
	input wire ir_link_pkg::rx_kind_t rx_kind_i,
	input wire logic [7:0] rx_slot_i,
	input wire logic [7:0] rx_addr_i,
	// Device outputs
	input wire logic tx_req_o,
	input wire ir_link_pkg::tx_kind_t tx_kind_o,
	input wire logic [7:0] tx_slot_o,
	input wire logic [7:0] tx_conn_addr_o,
	input wire logic [13:0] tx_baud_o,
	input wire logic tx_modem_o,
	input wire logic host_rx_ready_o,
	input wire logic cts_b_o,
	input wire logic dsr_b_o,
	input wire logic ir_activity_indicator_o,
	input wire ir_link_pkg::link_state_t link_state_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	logic good;
	assign good = rx_frame_valid_i && rx_crc_ok_i;

	a_slot_zero: assert property (
		tx_req_o |-> tx_slot_o == 8'h00) else $error("answer outside slot zero");
	a_xid_answer: assert property (
		good && rx_kind_i == ir_link_pkg::RX_XID && rx_slot_i == 8'h00
		&& link_state_o == ir_link_pkg::LS_NDM_IDLE |=> tx_req_o
		&& tx_kind_o == ir_link_pkg::TX_XID_RSP) else $error("slot zero not answered");
	a_bcast_quiet: assert property (
		good && rx_kind_i == ir_link_pkg::RX_BCAST_ID && link_state_o == ir_link_pkg::LS_NDM_CLAIMED
		|=> !tx_req_o && link_state_o == ir_link_pkg::LS_DISC_LINK) else $error("broadcast step");
	a_modem_rate: assert property (
		tx_req_o && tx_kind_o == ir_link_pkg::TX_UA_PARAMS |-> tx_baud_o == 14'h2580 && tx_modem_o)
		else $error("advertised rate or class wrong");
	a_snrm_addr: assert property (
		good && rx_kind_i == ir_link_pkg::RX_SNRM && link_state_o == ir_link_pkg::LS_DISC_LINK
		|=> tx_req_o && tx_conn_addr_o == $past(rx_addr_i)) else $error("ua address wrong");
	a_cts_off: assert property (
		link_state_o != ir_link_pkg::LS_NCM |-> cts_b_o) else $error("cts active unconnected");
	a_cts_full: assert property (
		!host_rx_ready_o |=> cts_b_o) else $error("cts active with full buffer");
	a_dsr_state: assert property (
		dsr_b_o == (link_state_o != ir_link_pkg::LS_NCM)) else $error("dsr mismatch");
	a_close_ack: assert property (
		good && rx_kind_i == ir_link_pkg::RX_CLOSE && link_state_o == ir_link_pkg::LS_NCM
		|=> tx_req_o && tx_kind_o == ir_link_pkg::TX_CLOSE_CONFIRM
		&& link_state_o == ir_link_pkg::LS_NDM_IDLE) else $error("close not confirmed");
	a_crc_reject: assert property (
		rx_frame_valid_i && !rx_crc_ok_i && rx_kind_i == ir_link_pkg::RX_INFO
		&& link_state_o == ir_link_pkg::LS_NCM |=> tx_req_o && tx_kind_o == ir_link_pkg::TX_REJECT)
		else $error("bad frame not rejected");
	a_lamp_on: assert property (
		good && rx_kind_i == ir_link_pkg::RX_XID |=> ir_activity_indicator_o) else $error("lamp off");
endmodule : ir_link_monitor

bind ir_link_connection_manager ir_link_monitor mon (.*);

`default_nettype wire

// ===== tb/ir_primary_model.sv
`timescale 1ns/1ns
`default_nettype none

module ir_primary_model (
	// Clock
	input wire logic mclk_i,
	// Frames toward the device
	output logic act_o,
	output logic fv_o,
	output logic crc_o,
	output ir_link_pkg::rx_kind_t kind_o,
	output logic [7:0] slot_o,
	output logic [7:0] addr_o,
	output ir_link_pkg::ias_item_t item_o,
	// Payload
	output logic bv_o,
	output logic [7:0] byte_o,
	output logic rdy_o
);
	// Stalls by default so the buffer can be seen to fill
	logic stall = 1'h1;
	assign rdy_o = !stall;
	initial begin
		{act_o, fv_o, crc_o, bv_o} = 4'h0;
		{slot_o, addr_o, byte_o} = 24'h0;
		kind_o = ir_link_pkg::RX_POLL;
		item_o = ir_link_pkg::IAS_UNKNOWN;
	end

	// Slot and address go stale after the pulse, so they are inverted
	task automatic frame(input ir_link_pkg::rx_kind_t k, input logic [7:0] s = 8'h00,
		input logic [7:0] a = 8'h00, input ir_link_pkg::ias_item_t q = ir_link_pkg::IAS_UNKNOWN,
		input logic ok = 1'h1);
		@(negedge mclk_i);
		{act_o, fv_o, crc_o} = {2'h3, ok};
		kind_o = k;
		slot_o = s;
		addr_o = a;
		item_o = q;
		@(negedge mclk_i);
		{act_o, fv_o, crc_o} = 3'h0;
		slot_o = ~s;
		addr_o = ~a;
	endtask : frame

	task automatic send_byte(input logic [7:0] b);
		@(negedge mclk_i);
		bv_o = 1'h1;
		byte_o = b;
		@(negedge mclk_i);
		bv_o = 1'h0;
		byte_o = ~b;
	endtask : send_byte
endmodule : ir_primary_model

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	localparam int unsigned TMO = 40;
	logic mclk_i, rst_b_i, rx_activity_i, rx_frame_valid_i, rx_crc_ok_i, rx_byte_valid_i;
	logic tx_byte_ready_i, host_rx_valid_i, tx_req_o, tx_modem_o, tx_byte_valid_o;
	logic host_rx_ready_o, host_tx_valid_o, cts_b_o, dsr_b_o, dcd_b_o, ri_b_o;
	logic ir_activity_indicator_o;
	logic [7:0] rx_slot_i, rx_addr_i, rx_byte_i, host_rx_byte_i, tx_slot_o, tx_conn_addr_o;
	logic [7:0] tx_turn_ms_o, tx_disc_wait_o, tx_byte_o, host_tx_byte_o;
	logic [13:0] tx_baud_o;
	logic [3:0] tx_window_o;
	ir_link_pkg::rx_kind_t rx_kind_i;
	ir_link_pkg::tx_kind_t tx_kind_o;
	ir_link_pkg::ias_item_t rx_ias_item_i, tx_ias_item_o;
	ir_link_pkg::link_state_t link_state_o;
	int err_total = 0;
	int comparisons = 0;

	ir_link_connection_manager #(.ACT_IDLE_CYCLES(50), .DISC_TIMEOUT_CYCLES(TMO)) uut (.*);
	ir_primary_model p (.mclk_i, .act_o(rx_activity_i), .fv_o(rx_frame_valid_i),
		.crc_o(rx_crc_ok_i), .kind_o(rx_kind_i), .slot_o(rx_slot_i), .addr_o(rx_addr_i),
		.item_o(rx_ias_item_i), .bv_o(rx_byte_valid_i), .byte_o(rx_byte_i),
		.rdy_o(tx_byte_ready_i));

	initial begin
		mclk_i = 1'h0;
		forever #10 mclk_i = ~mclk_i;
	end

	// ----
	// Checking helpers
	// ----
	task automatic chk(input logic c, input string m);
		comparisons++;
		if (c !== 1'h1) begin
			err_total++;
			$display("wrong value at %0t ns: %s", $time, m);
		end
	endtask : chk

	task automatic rq(input ir_link_pkg::tx_kind_t k);
		chk(tx_req_o === 1'h1 && tx_kind_o === k, "response kind");
	endtask : rq

	task automatic wrap_up;
		if (err_total == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		chk(link_state_o === ir_link_pkg::LS_NDM_IDLE && tx_req_o === 1'h0, "reset state");
		chk({cts_b_o, dsr_b_o, dcd_b_o, ri_b_o, ir_activity_indicator_o} === 5'h1E, "lines");
		chk(tx_baud_o === 14'h2580 && tx_slot_o === 8'h00, "advertised");
	endtask : t_reset

	task automatic t_ndm;
		for (int i = 0; i < 6; i++) begin
			p.frame(ir_link_pkg::RX_XID, 8'(i));
			if (i == 0) begin
				rq(ir_link_pkg::TX_XID_RSP);
				chk(ir_activity_indicator_o === 1'h1, "lamp");
			end else begin
				chk(tx_req_o === 1'h0, "extra slot answer");
			end
		end
		p.frame(ir_link_pkg::RX_SNRM);
		chk(tx_req_o === 1'h0 && link_state_o === ir_link_pkg::LS_NDM_CLAIMED, "early");
		p.frame(ir_link_pkg::RX_BCAST_ID);
		chk(tx_req_o === 1'h0 && link_state_o === ir_link_pkg::LS_DISC_LINK, "bcast");
		chk(cts_b_o === 1'h1, "cts idle");
	endtask : t_ndm

	task automatic t_disc;
		p.frame(ir_link_pkg::RX_SNRM, 8'h00, 8'h5A);
		rq(ir_link_pkg::TX_UA_PARAMS);
		chk(tx_conn_addr_o === 8'h5A && tx_baud_o === 14'h2580, "ua fields");
		chk(tx_turn_ms_o === 8'h0A && tx_window_o === 4'h1 && tx_disc_wait_o === 8'h03, "prm");
		chk(tx_modem_o === 1'h1, "class");
		p.frame(ir_link_pkg::RX_IAS_OPEN);
		rq(ir_link_pkg::TX_IAS_CONFIRM);
		for (int q = 0; q < 3; q++) begin
			p.frame(ir_link_pkg::RX_IAS_QUERY, 8'h00, 8'h00, ir_link_pkg::ias_item_t'(q));
			rq(ir_link_pkg::TX_IAS_ANSWER);
			chk(tx_ias_item_o === ir_link_pkg::ias_item_t'(q), "query item");
		end
		p.frame(ir_link_pkg::RX_POLL);
		rq(ir_link_pkg::TX_KEEPALIVE);
		chk(cts_b_o === 1'h1 && dsr_b_o === 1'h1, "discovery lines");
		p.frame(ir_link_pkg::RX_DATA_OPEN);
		rq(ir_link_pkg::TX_DATA_CONFIRM);
		chk(dsr_b_o === 1'h0 && cts_b_o === 1'h0, "connected lines");
		chk(dcd_b_o === 1'h1 && ri_b_o === 1'h1, "other lines");
	endtask : t_disc

	task automatic t_ncm;
		p.frame(ir_link_pkg::RX_POLL);
		rq(ir_link_pkg::TX_KEEPALIVE);
		for (int i = 0; i < 8 && cts_b_o === 1'h0; i++) begin
			host_rx_valid_i = 1'h1;
			host_rx_byte_i = 8'hA0 + 8'(i);
			@(negedge mclk_i);
		end
		host_rx_valid_i = 1'h0;
		chk(host_rx_ready_o === 1'h0 && tx_byte_valid_o === 1'h1, "full");
		@(negedge mclk_i);
		chk(cts_b_o === 1'h1, "cts full");
		p.frame(ir_link_pkg::RX_POLL);
		rq(ir_link_pkg::TX_INFO);
		p.frame(ir_link_pkg::RX_INFO, 8'h00, 8'h00, ir_link_pkg::IAS_UNKNOWN, 1'h0);
		rq(ir_link_pkg::TX_REJECT);
		p.send_byte(8'h3C);
		chk(host_tx_valid_o === 1'h1 && host_tx_byte_o === 8'h3C, "to host");
		for (int i = 0; i < 8; i++) begin
			chk(tx_byte_valid_o === 1'h1 && tx_byte_o === 8'hA0 + 8'(i), "order");
			p.stall = 1'h0;
			@(negedge mclk_i);
			p.stall = 1'h1;
			repeat (2) @(negedge mclk_i);
		end
		chk(tx_byte_valid_o === 1'h0 && cts_b_o === 1'h0, "drained");
		p.frame(ir_link_pkg::RX_INFO);
		rq(ir_link_pkg::TX_KEEPALIVE);
	endtask : t_ncm

	task automatic t_disc_close;
		t_ndm();
		p.frame(ir_link_pkg::RX_POLL);
		rq(ir_link_pkg::TX_KEEPALIVE);
		p.frame(ir_link_pkg::RX_SNRM, 8'h00, 8'h33, ir_link_pkg::IAS_UNKNOWN, 1'h0);
		chk(tx_req_o === 1'h0 && link_state_o === ir_link_pkg::LS_DISC_LINK, "bad crc");
		p.frame(ir_link_pkg::RX_SNRM, 8'h00, 8'h33);
		chk(tx_conn_addr_o === 8'h33 && link_state_o === ir_link_pkg::LS_DISC_IAS, "addr");
		p.frame(ir_link_pkg::RX_CLOSE);
		rq(ir_link_pkg::TX_CLOSE_CONFIRM);
		chk(link_state_o === ir_link_pkg::LS_NDM_IDLE && cts_b_o === 1'h1, "idle close");
	endtask : t_disc_close

	task automatic t_close;
		p.frame(ir_link_pkg::RX_CLOSE);
		rq(ir_link_pkg::TX_CLOSE_CONFIRM);
		chk(link_state_o === ir_link_pkg::LS_NDM_IDLE && dsr_b_o === 1'h1, "closed");
	endtask : t_close

	task automatic t_timeout;
		t_ndm();
		t_disc();
		repeat (TMO - 5) @(negedge mclk_i);
		chk(link_state_o === ir_link_pkg::LS_NCM, "early drop");
		p.frame(ir_link_pkg::RX_POLL);
		repeat (TMO - 5) @(negedge mclk_i);
		chk(link_state_o === ir_link_pkg::LS_NCM, "restart");
		repeat (10) @(negedge mclk_i);
		chk(link_state_o === ir_link_pkg::LS_NDM_IDLE && dsr_b_o === 1'h1, "timeout");
		chk(ir_activity_indicator_o === 1'h1, "lamp held");
		repeat (15) @(negedge mclk_i);
		chk(ir_activity_indicator_o === 1'h0, "lamp idle");
	endtask : t_timeout

	initial begin
		rst_b_i = 1'h0;
		host_rx_valid_i = 1'h0;
		host_rx_byte_i = 8'h00;
		repeat (16) @(negedge mclk_i);
		rst_b_i = 1'h1;
		@(negedge mclk_i);
		t_reset();
		t_ndm();
		t_disc();
		t_ncm();
		t_close();
		t_disc_close();
		t_timeout();
		wrap_up();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk_i);
		err_total++;
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
